// [hw/slcd_consts.vh]
`ifndef SLCD_CONSTS_VH
`define SLCD_CONSTS_VH

// ----------------------------------------
// Register map
// ----------------------------------------
`define SLCD_A_CTRLA     6'h00
`define SLCD_A_CTRLB     6'h01
`define SLCD_A_FRR       6'h02
`define SLCD_A_CCR       6'h03
`define SLCD_A_STAT      6'h04
`define SLCD_A_DMEM_LO   6'h10
`define SLCD_A_DMEM_HI   6'h23
`define SLCD_RST_BYTE    8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SLCD_B_EN        7
`define SLCD_B_LPW       6
`define SLCD_B_FLAG      4
`define SLCD_B_BLANK     0
`define SLCD_B_ASYNC     7
`define SLCD_B_HALF      6
`define SLCD_F_DUTY      5:4
`define SLCD_F_PMASK     3:0
`define SLCD_F_PS        6:4
`define SLCD_F_CD        2:0
`define SLCD_F_DT        7:5
`define SLCD_F_CC        3:0
`define SLCD_FRR_MASK    8'h77
`define SLCD_CCR_MASK    8'hEF

// ----------------------------------------
// Sizes, levels and timing
// ----------------------------------------
`define SLCD_NDMEM       20
`define SLCD_NSEG        40
`define SLCD_NCOM        4
`define SLCD_LV_0        2'h0
`define SLCD_LV_1        2'h1
`define SLCD_LV_2        2'h2
`define SLCD_LV_3        2'h3
`define SLCD_DUTY_STAT   2'h0
`define SLCD_DRV_SHIFT   2

// ----------------------------------------
// Sleep mode codes
// ----------------------------------------
`define SLCD_SM_ACTIVE   3'h0
`define SLCD_SM_IDLE     3'h1
`define SLCD_SM_ADCNR    3'h2
`define SLCD_SM_PDOWN    3'h3
`define SLCD_SM_PSAVE    3'h4
`define SLCD_SM_STBY     3'h5

`endif

// [hw/slcd_dmem.v]
`timescale 1ns/1ps
`include "slcd_consts.vh"

module slcd_dmem (
  // System
  input  wire         clock,
  input  wire         rst,
  // Software port
  input  wire         wr_en,
  input  wire [4:0]   wr_idx,
  input  wire [7:0]   wr_data,
  input  wire [4:0]   rd_idx,
  output reg  [7:0]   rd_data,
  // Frame latch
  input  wire         snap,
  output reg  [159:0] frame_bits
);

  reg [7:0] mem_r [0:`SLCD_NDMEM-1];
  integer   i;

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_data    <= `SLCD_RST_BYTE;
      frame_bits <= 160'h0;
      for (i = 0; i < `SLCD_NDMEM; i = i + 1) begin
        mem_r[i] <= `SLCD_RST_BYTE;
      end
    end else begin
      if (wr_en) begin
        mem_r[wr_idx] <= wr_data;
      end
      rd_data <= mem_r[rd_idx];
      // Snapshot sees memory before a write in the same cycle
      if (snap) begin
        for (i = 0; i < `SLCD_NDMEM; i = i + 1) begin
          frame_bits[i*8 +: 8] <= mem_r[i];
        end
      end
    end
  end

endmodule // slcd_dmem

// [hw/slcd_ctrl.v]
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "slcd_consts.vh"
// Function
// - Clock from system clock; timer oscillator pin when async selected.
// - 12-bit prescaler divides LCD clock by 16 up to 4096.
// - Further divide by 1 to 8 gives the prescaled LCD clock.
// - Memory bit one energises segment, zero leaves it off.
// - On segment opposite phase to common; off segment in phase.
// - Half bias adds one intermediate level, third bias adds two.
// - Frame starts at common 0 using first five latched bytes.
// - Then common 1 with next five bytes, until duty commons done.
// - Memory, blank, waveform, contrast latched before each default-waveform frame.
// - Outputs inhibited until drive voltage reaches target.
// - Buffers on for drive time after transition, then tristated.
// - Multi-common drive time capped at half prescaled period.
// - Low power waveform latches and flags every second frame.
// - Synchronous clock keeps running in Idle and Power-save.
// - Async clock with RC system clock runs in Idle, ADC NR, Power-save.
// - External clock enable selects input buffer instead of crystal.
// - Blank after current frame; all pins to ground, memory kept.
// - Masked segments and unused commons return to port function.
// - Flag set at frame latch; cleared by vector ack or write one.
// - Clearing enable turns LCD off at once, pins to port.
// - Duty select picks static, half, third or quarter commons.
// - Half bias select clear gives third bias, set gives half.

module slcd_ctrl (
  // System
  input  wire         clock,
  input  wire         rst,
  // Register port
  input  wire [5:0]   reg_addr,
  input  wire [7:0]   reg_wdata,
  input  wire         reg_wr,
  input  wire         reg_rd,
  output wire [7:0]   reg_rdata,
  // Clock source
  input  wire         timer_osc_pin,
  input  wire         external_clock_enable,
  input  wire         rc_sysclk,
  output wire         osc_ext_buf_en,
  output wire         osc_xtal_en,
  // Power
  input  wire [2:0]   sleep_mode,
  input  wire         vlcd_ready_pin,
  output wire         io_clock_keep,
  output wire         osc_clock_keep,
  output reg  [3:0]   contrast_level,
  // Frame flag
  input  wire         flag_vector_ack,
  output wire         frame_start_flag,
  // Panel
  output reg          prescaled_lcd_clock,
  output reg  [7:0]   com_level,
  output reg  [3:0]   com_oe,
  output reg  [3:0]   com_lcd_mode,
  output reg  [79:0]  seg_level,
  output reg  [39:0]  seg_oe,
  output reg  [39:0]  seg_lcd_mode
);

  localparam ST_OFF = 1'b0;
  localparam ST_RUN = 1'b1;

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function [11:0] pre_mask;
    input [2:0] sel;
    begin
      case (sel)
        3'h0:    pre_mask = 12'h00F;
        3'h1:    pre_mask = 12'h03F;
        3'h2:    pre_mask = 12'h07F;
        3'h3:    pre_mask = 12'h0FF;
        3'h4:    pre_mask = 12'h1FF;
        3'h5:    pre_mask = 12'h3FF;
        3'h6:    pre_mask = 12'h7FF;
        default: pre_mask = 12'hFFF;
      endcase
    end
  endfunction

  function [5:0] seg_count;
    input [3:0] pm;
    begin
      case (pm)
        4'h0:    seg_count = 6'h0D;
        4'h1:    seg_count = 6'h0F;
        4'h2:    seg_count = 6'h11;
        4'h3:    seg_count = 6'h13;
        4'h4:    seg_count = 6'h15;
        4'h5:    seg_count = 6'h17;
        4'h6:    seg_count = 6'h18;
        4'h7:    seg_count = 6'h19;
        4'h8:    seg_count = 6'h1B;
        4'h9:    seg_count = 6'h1D;
        4'hA:    seg_count = 6'h1F;
        4'hB:    seg_count = 6'h21;
        4'hC:    seg_count = 6'h23;
        4'hD:    seg_count = 6'h25;
        4'hE:    seg_count = 6'h27;
        default: seg_count = 6'h28;
      endcase
    end
  endfunction

  function [1:0] mirror;
    input [1:0] lv;
    input [1:0] top;
    input       pol;
    begin
      mirror = pol ? lv : top - lv;
    end
  endfunction

  // ----------------------------------------
  // Registers and state
  // ----------------------------------------
  reg         en_r;
  reg         lpw_r;
  reg         blank_r;
  reg         flag_r;
  reg  [7:0]  ctrlb_r;
  reg  [7:0]  frr_r;
  reg  [7:0]  ccr_r;
  reg         osc_s1_r;
  reg         osc_s2_r;
  reg         osc_s3_r;
  reg         vrdy_s1_r;
  reg         vrdy_s2_r;
  reg  [11:0] pre_cnt_r;
  reg  [2:0]  div_cnt_r;
  reg         state_r;
  reg  [1:0]  com_idx_r;
  reg         half_r;
  reg         pol_r;
  reg         odd_r;
  reg         lat_lpw_r;
  reg         lat_blank_r;
  reg         drv_on_r;
  reg  [15:0] drv_cnt_r;
  reg  [7:0]  csr_rdata_r;
  reg         dmem_hit_r;

  wire        async_sel = ctrlb_r[`SLCD_B_ASYNC];
  wire [1:0]  duty      = ctrlb_r[`SLCD_F_DUTY];
  wire        static_m  = (duty == `SLCD_DUTY_STAT);
  wire [2:0]  cd_sel    = frr_r[`SLCD_F_CD];
  wire [11:0] pmask     = pre_mask(frr_r[`SLCD_F_PS]);
  wire [5:0]  nseg      = seg_count(ctrlb_r[`SLCD_F_PMASK]);
  wire        run       = (state_r == ST_RUN);
  wire        dmem_hit  = (reg_addr >= `SLCD_A_DMEM_LO) &&
                          (reg_addr <= `SLCD_A_DMEM_HI);
  wire [5:0]  dmem_off  = reg_addr - `SLCD_A_DMEM_LO;
  wire [7:0]  dmem_rd;
  wire [159:0] fbits;

  // ----------------------------------------
  // Clock source and prescaler
  // ----------------------------------------
  // clock source select
  wire lcd_tick = async_sel ? (osc_s2_r & ~osc_s3_r) : 1'b1;
  assign osc_ext_buf_en = async_sel & external_clock_enable;
  assign osc_xtal_en    = async_sel & ~external_clock_enable;

  wire pre_tick = lcd_tick && ((pre_cnt_r & pmask) == pmask);
  wire ps_tick  = pre_tick && (div_cnt_r == cd_sel);

  // Synchronous counter stands in for the ripple chain: same taps, no skew
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      osc_s1_r            <= 1'b0;
      osc_s2_r            <= 1'b0;
      osc_s3_r            <= 1'b0;
      vrdy_s1_r           <= 1'b0;
      vrdy_s2_r           <= 1'b0;
      pre_cnt_r           <= 12'h000;
      div_cnt_r           <= 3'h0;
      prescaled_lcd_clock <= 1'b0;
    end else begin
      osc_s1_r  <= timer_osc_pin;
      osc_s2_r  <= osc_s1_r;
      osc_s3_r  <= osc_s2_r;
      vrdy_s1_r <= vlcd_ready_pin;
      vrdy_s2_r <= vrdy_s1_r;
      if (!en_r) begin
        pre_cnt_r           <= 12'h000;
        div_cnt_r           <= 3'h0;
        prescaled_lcd_clock <= 1'b0;
      end else begin
        if (lcd_tick) begin
          pre_cnt_r <= pre_cnt_r + 12'h001;
        end
        if (ps_tick) begin
          div_cnt_r           <= 3'h0;
          prescaled_lcd_clock <= ~prescaled_lcd_clock;
        end else if (pre_tick) begin
          div_cnt_r <= div_cnt_r + 3'h1;
        end
      end
    end
  end

  // ----------------------------------------
  // Frame sequencer
  // ----------------------------------------
  // Default waveform spends two phases per common; low power spends one
  wire phase_end = lat_lpw_r | half_r;
  wire frame_end = run && ps_tick && phase_end && (com_idx_r == duty);
  // latch every second frame in low power mode
  wire do_latch  = (!run && en_r && lcd_tick) ||
                   (frame_end && (!lat_lpw_r || odd_r));
  wire eff_pol   = lat_lpw_r ? pol_r : ~half_r;

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r     <= ST_OFF;
      com_idx_r   <= 2'h0;
      half_r      <= 1'b0;
      pol_r       <= 1'b1;
      odd_r       <= 1'b0;
      lat_lpw_r   <= 1'b0;
      lat_blank_r <= 1'b0;
      contrast_level <= 4'h0;
    end else begin
      if (do_latch) begin
        lat_lpw_r      <= lpw_r;
        lat_blank_r    <= blank_r;
        contrast_level <= ccr_r[`SLCD_F_CC];
      end
      case (state_r)
        ST_OFF: begin
          com_idx_r <= 2'h0;
          half_r    <= 1'b0;
          pol_r     <= 1'b1;
          odd_r     <= 1'b0;
          if (en_r && lcd_tick) begin
            state_r <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (!en_r) begin
            state_r <= ST_OFF;
          end else if (ps_tick) begin
            if (!phase_end) begin
              half_r <= 1'b1;
            end else begin
              half_r <= 1'b0;
              if (com_idx_r == duty) begin
                com_idx_r <= 2'h0;
                odd_r     <= ~do_latch;
                pol_r     <= do_latch;
              end else begin
                com_idx_r <= com_idx_r + 2'h1;
              end
            end
          end
        end
        default: state_r <= ST_OFF;
      endcase
    end
  end

  // ----------------------------------------
  // Drive window
  // ----------------------------------------
  wire [15:0] ps_period = ({4'h0, pmask} + 16'h0001) * ({13'h0000, cd_sel} + 16'h0001);
  wire [15:0] drv_want  = {12'h000, 1'b0, ccr_r[`SLCD_F_DT]} + 16'h0001;
  wire [15:0] drv_tgt   = drv_want << `SLCD_DRV_SHIFT;
  wire [15:0] half_per  = ps_period >> 1;
  wire [15:0] drv_lim   = (!static_m && half_per < drv_tgt) ? half_per : drv_tgt;

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      drv_on_r  <= 1'b0;
      drv_cnt_r <= 16'h0000;
    end else if (!en_r) begin
      drv_on_r  <= 1'b0;
      drv_cnt_r <= 16'h0000;
    end else if ((run && ps_tick) || (!run && lcd_tick)) begin
      drv_on_r  <= 1'b1;
      drv_cnt_r <= 16'h0000;
    end else if (drv_on_r && lcd_tick) begin
      if (drv_cnt_r + 16'h0001 >= drv_lim) begin
        drv_on_r <= 1'b0;
      end
      drv_cnt_r <= drv_cnt_r + 16'h0001;
    end
  end

  // ----------------------------------------
  // Pin levels
  // ----------------------------------------
  // bias choice sets the top level
  wire [1:0] top    = (static_m || !ctrlb_r[`SLCD_B_HALF]) ? `SLCD_LV_3 : `SLCD_LV_2;
  wire [1:0] com_un = static_m ? `SLCD_LV_0 : `SLCD_LV_1;
  wire [1:0] seg_of = static_m ? top : `SLCD_LV_2;
  // inhibit until drive voltage ready
  // Enable gates too, so buffers drop in the same cycle the pins go back to port
  wire       pin_oe = run && en_r && vrdy_s2_r && (lat_blank_r || drv_on_r);

  genvar g;
  generate
    for (g = 0; g < `SLCD_NCOM; g = g + 1) begin : g_com
      always @(posedge clock or posedge rst) begin
        if (rst) begin
          com_level[g*2 +: 2] <= `SLCD_LV_0;
          com_oe[g]           <= 1'b0;
          com_lcd_mode[g]     <= 1'b0;
        end else begin
          if (lat_blank_r) begin
            com_level[g*2 +: 2] <= `SLCD_LV_0;
          end else if (com_idx_r == g) begin
            com_level[g*2 +: 2] <= mirror(top, top, eff_pol);
          end else begin
            com_level[g*2 +: 2] <= mirror(com_un, top, eff_pol);
          end
          com_oe[g] <= pin_oe && (g <= duty);
          com_lcd_mode[g] <= en_r && (g <= duty);
        end
      end
    end
    for (g = 0; g < `SLCD_NSEG; g = g + 1) begin : g_seg
      always @(posedge clock or posedge rst) begin
        if (rst) begin
          seg_level[g*2 +: 2] <= `SLCD_LV_0;
          seg_oe[g]           <= 1'b0;
          seg_lcd_mode[g]     <= 1'b0;
        end else begin
          if (lat_blank_r) begin
            seg_level[g*2 +: 2] <= `SLCD_LV_0;
          end else if (fbits[com_idx_r*`SLCD_NSEG + g]) begin
            seg_level[g*2 +: 2] <= mirror(`SLCD_LV_0, top, eff_pol);
          end else begin
            seg_level[g*2 +: 2] <= mirror(seg_of, top, eff_pol);
          end
          seg_oe[g] <= pin_oe && (g < nseg);
          seg_lcd_mode[g] <= en_r && (g < nseg);
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Sleep hand-off
  // ----------------------------------------
  // synchronous source kept in idle and power-save
  assign io_clock_keep  = en_r && !async_sel &&
                          (sleep_mode == `SLCD_SM_ACTIVE ||
                           sleep_mode == `SLCD_SM_IDLE ||
                           sleep_mode == `SLCD_SM_PSAVE);
  // async source kept in idle, ADC noise reduction, power-save only with RC system clock
  assign osc_clock_keep = en_r && async_sel &&
                          (sleep_mode == `SLCD_SM_ACTIVE ||
                           (rc_sysclk && (sleep_mode == `SLCD_SM_IDLE ||
                                          sleep_mode == `SLCD_SM_ADCNR ||
                                          sleep_mode == `SLCD_SM_PSAVE)));

  // ----------------------------------------
  // Register port
  // ----------------------------------------
  wire wr_a    = reg_wr && (reg_addr == `SLCD_A_CTRLA);
  wire flag_clr = flag_vector_ack || (wr_a && reg_wdata[`SLCD_B_FLAG]);
  assign frame_start_flag = flag_r;
  assign reg_rdata        = dmem_hit_r ? dmem_rd : csr_rdata_r;

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      en_r        <= 1'b0;
      lpw_r       <= 1'b0;
      blank_r     <= 1'b0;
      flag_r      <= 1'b0;
      ctrlb_r     <= `SLCD_RST_BYTE;
      frr_r       <= `SLCD_RST_BYTE;
      ccr_r       <= `SLCD_RST_BYTE;
      csr_rdata_r <= `SLCD_RST_BYTE;
      dmem_hit_r  <= 1'b0;
    end else begin
      flag_r <= do_latch | (flag_r & ~flag_clr);
      if (wr_a) begin
        en_r    <= reg_wdata[`SLCD_B_EN];
        lpw_r   <= reg_wdata[`SLCD_B_LPW];
        blank_r <= reg_wdata[`SLCD_B_BLANK];
      end
      if (reg_wr && reg_addr == `SLCD_A_CTRLB) begin
        ctrlb_r <= reg_wdata;
      end
      if (reg_wr && reg_addr == `SLCD_A_FRR) begin
        frr_r <= reg_wdata & `SLCD_FRR_MASK;
      end
      if (reg_wr && reg_addr == `SLCD_A_CCR) begin
        ccr_r <= reg_wdata & `SLCD_CCR_MASK;
      end
      dmem_hit_r  <= reg_rd && dmem_hit;
      csr_rdata_r <= `SLCD_RST_BYTE;
      if (reg_rd) begin
        case (reg_addr)
          `SLCD_A_CTRLA: csr_rdata_r <= {en_r, lpw_r, 1'b0, flag_r, 3'h0, blank_r};
          `SLCD_A_CTRLB: csr_rdata_r <= ctrlb_r;
          `SLCD_A_FRR:   csr_rdata_r <= frr_r;
          `SLCD_A_CCR:   csr_rdata_r <= ccr_r;
          `SLCD_A_STAT:  csr_rdata_r <= {run, lat_blank_r, lat_lpw_r, drv_on_r,
                                         com_idx_r, eff_pol, vrdy_s2_r};
          default:       csr_rdata_r <= `SLCD_RST_BYTE;
        endcase
      end
    end
  end

  // writes accepted any time; frame uses the snapshot
  slcd_dmem u_dmem (
    .clock      (clock),
    .rst        (rst),
    .wr_en      (reg_wr && dmem_hit),
    .wr_idx     (dmem_off[4:0]),
    .wr_data    (reg_wdata),
    .rd_idx     (dmem_off[4:0]),
    .rd_data    (dmem_rd),
    .snap       (do_latch),
    .frame_bits (fbits)
  );

endmodule // slcd_ctrl

// [tb/slcd_monitor.sv]
`timescale 1ns/1ps
`include "slcd_consts.vh"

module slcd_monitor (
  // System
  input wire         clock,
  input wire         rst,
  // Register port
  input wire [5:0]   reg_addr,
  input wire [7:0]   reg_wdata,
  input wire         reg_wr,
  input wire         reg_rd,
  input wire [7:0]   reg_rdata,
  // Clock source and power
  input wire         external_clock_enable,
  input wire         osc_ext_buf_en,
  input wire         osc_xtal_en,
  input wire         io_clock_keep,
  input wire         osc_clock_keep,
  input wire         vlcd_ready_pin,
  // Panel
  input wire         frame_start_flag,
  input wire         prescaled_lcd_clock,
  input wire [3:0]   com_oe,
  input wire [3:0]   com_lcd_mode,
  input wire [39:0]  seg_oe,
  input wire [39:0]  seg_lcd_mode
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_dis_wr;
    reg_wr && reg_addr == `SLCD_A_CTRLA && !reg_wdata[`SLCD_B_EN];
  endsequence
  sequence s_pins_port;
    com_lcd_mode == 4'h0 && seg_lcd_mode == 40'h0 && com_oe == 4'h0 && seg_oe == 40'h0;
  endsequence

  property p_dis; s_dis_wr |=> ##1 s_pins_port; endproperty
  a_dis: assert property (p_dis) else $error("pins kept after disable");
  property p_rdata; !reg_rd |=> reg_rdata == 8'h00; endproperty
  a_rdata: assert property (p_rdata) else $error("read data outside slot");
  property p_com_own; (com_oe & ~com_lcd_mode) == 4'h0; endproperty
  a_com_own: assert property (p_com_own) else $error("port common driven");
  property p_seg_own; (seg_oe & ~seg_lcd_mode) == 40'h0; endproperty
  a_seg_own: assert property (p_seg_own) else $error("masked segment driven");
  property p_keep; !(io_clock_keep && osc_clock_keep); endproperty
  a_keep: assert property (p_keep) else $error("both clocks kept");
  property p_osc;
    !(osc_ext_buf_en && !external_clock_enable) && !(osc_xtal_en && external_clock_enable);
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator select wrong");
  property p_vlcd; !vlcd_ready_pin [*4] |-> com_oe == 4'h0 && seg_oe == 40'h0; endproperty
  a_vlcd: assert property (p_vlcd) else $error("drive before voltage ready");
  property p_flag; $rose(frame_start_flag) |-> ##[0:2] com_lcd_mode[0]; endproperty
  a_flag: assert property (p_flag) else $error("flag without running frame");
  property p_ps;
    $changed(prescaled_lcd_clock) && com_lcd_mode[0]
      |=> ($stable(prescaled_lcd_clock) || !com_lcd_mode[0]) [*8];
  endproperty
  a_ps: assert property (p_ps) else $error("prescaled clock too fast");
endmodule // slcd_monitor

bind slcd_ctrl slcd_monitor u_mon (
  .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .external_clock_enable(external_clock_enable), .osc_ext_buf_en(osc_ext_buf_en),
  .osc_xtal_en(osc_xtal_en), .io_clock_keep(io_clock_keep),
  .osc_clock_keep(osc_clock_keep), .vlcd_ready_pin(vlcd_ready_pin),
  .frame_start_flag(frame_start_flag), .prescaled_lcd_clock(prescaled_lcd_clock),
  .com_oe(com_oe), .com_lcd_mode(com_lcd_mode), .seg_oe(seg_oe),
  .seg_lcd_mode(seg_lcd_mode));

// [tb/slcd_panel_model.sv]
`timescale 1ns/1ps

module slcd_panel_model (
  // System
  input wire           clock,
  input wire           clr,
  // Panel pins
  input wire [7:0]     com_level,
  input wire [3:0]     com_oe,
  input wire [79:0]    seg_level,
  input wire [39:0]    seg_oe,
  // Cells seen energised, common-major
  output logic [159:0] lit
);
  int d;

  // a cell lights only across two or more level steps
  always @(posedge clock) begin
    if (clr) begin
      lit <= '0;
    end else begin
      for (int c = 0; c < 4; c++) begin
        for (int s = 0; s < 40; s++) begin
          d = int'(com_level[2*c +: 2]) - int'(seg_level[2*s +: 2]);
          if (com_oe[c] && seg_oe[s] && (d >= 2 || d <= -2)) lit[c*40+s] <= 1'h1;
        end
      end
    end
  end
endmodule // slcd_panel_model

// [tb/tb_top.sv]
`timescale 1ns/1ps
`include "slcd_consts.vh"

module tb_top;
  logic         clock, rst, reg_wr, reg_rd, timer_osc_pin, external_clock_enable;
  logic         rc_sysclk, vlcd_ready_pin, flag_vector_ack, clr, asy, ext, rc;
  logic [5:0]   reg_addr;
  logic [7:0]   reg_wdata;
  logic [2:0]   sleep_mode;
  logic [3:0]   e4;
  logic [7:0]   dm [20];
  wire  [7:0]   reg_rdata, com_level;
  wire  [3:0]   contrast_level, com_oe, com_lcd_mode;
  wire  [79:0]  seg_level;
  wire  [39:0]  seg_oe, seg_lcd_mode;
  wire  [159:0] lit;
  wire          osc_ext_buf_en, osc_xtal_en, io_clock_keep, osc_clock_keep;
  wire          frame_start_flag, prescaled_lcd_clock;
  int           failures, checks_done, n, osc_cnt, d, pm, ps, cd;

  slcd_ctrl DUT (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_osc_pin(timer_osc_pin),
    .external_clock_enable(external_clock_enable), .rc_sysclk(rc_sysclk),
    .osc_ext_buf_en(osc_ext_buf_en), .osc_xtal_en(osc_xtal_en), .sleep_mode(sleep_mode),
    .vlcd_ready_pin(vlcd_ready_pin), .io_clock_keep(io_clock_keep),
    .osc_clock_keep(osc_clock_keep), .contrast_level(contrast_level),
    .flag_vector_ack(flag_vector_ack), .frame_start_flag(frame_start_flag),
    .prescaled_lcd_clock(prescaled_lcd_clock), .com_level(com_level), .com_oe(com_oe),
    .com_lcd_mode(com_lcd_mode), .seg_level(seg_level), .seg_oe(seg_oe),
    .seg_lcd_mode(seg_lcd_mode));
  slcd_panel_model u_panel (.clock(clock), .clr(clr), .com_level(com_level),
    .com_oe(com_oe), .seg_level(seg_level), .seg_oe(seg_oe), .lit(lit));

  initial begin
    clock = 1'h0;
    forever #10 clock = ~clock;
  end
  // Timer oscillator pin: period of ten system clocks, edges on the clock grid
  always @(posedge clock) begin
    osc_cnt <= osc_cnt == 4 ? 0 : osc_cnt + 1;
    if (osc_cnt == 4) timer_osc_pin <= ~timer_osc_pin;
  end
  initial begin
    #2000000;
    failures++;
    give_verdict;
  end

  // ------------------------------
  // Bus, compare and model helpers
  // ------------------------------
  task tick; @(posedge clock); #1; endtask
  task wr(input logic [5:0] a, input logic [7:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'h1;
    @(posedge clock);
    reg_wr <= 1'h0;
  endtask
  task rd(input logic [5:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clock);
    reg_rd <= 1'h0;
    #1 cmp(reg_rdata, e);
  endtask
  task cmp(input logic [159:0] g, input logic [159:0] e);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %0t got %0h expected %0h", $time, g, e);
    end
  endtask
  // Cycles until the prescaled clock next changes
  task meas(output int c);
    logic p;
    p = prescaled_lcd_clock;
    c = 0;
    while (prescaled_lcd_clock === p && c < 9000) begin
      tick;
      c++;
    end
  endtask
  task wait_flag;
    int c;
    #1;
    c = 0;
    while (frame_start_flag !== 1'h1 && c < 1000) begin
      tick;
      c++;
    end
    cmp(frame_start_flag, 1'h1);
  endtask
  function automatic int nseg(int p);
    return p < 6 ? 13 + 2 * p : p < 8 ? p + 18 : p == 15 ? 40 : 11 + 2 * p;
  endfunction
  function automatic logic [159:0] exp_lit(int du, int p);
    logic [159:0] v;
    v = '0;
    for (int k = 0; k < 160; k++) begin
      if (k / 40 <= du && k % 40 < nseg(p)) v[k] = dm[k / 8][k % 8];
    end
    return v;
  endfunction
  task give_verdict;
    if (failures == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    {rst, reg_wr, reg_rd, clr, flag_vector_ack, vlcd_ready_pin} = 6'h20;
    {timer_osc_pin, external_clock_enable, rc_sysclk, asy, ext, rc} = 6'h00;
    {reg_addr, reg_wdata, sleep_mode, osc_cnt} = '0;
    void'($urandom(32'hFF3E));
    repeat (3) @(posedge clock);
    rst <= 1'h0;
    for (int a = 0; a < 5; a++) rd(a == 4 ? 6'h3F : 6'(a), 8'h00);
    wr(`SLCD_A_CTRLA, 8'h80);
    for (int i = 0; i < 8; i++) begin
      {rc, ext, asy} = i[2:0];
      wr(`SLCD_A_CTRLB, {asy, 7'h00});
      for (int m = 0; m < 6; m++) begin
        @(posedge clock);
        sleep_mode <= `SLCD_SM_ACTIVE;
        wr(`SLCD_A_CTRLA, {asy | (m < 2) | (m == 4), 7'h00});
        @(posedge clock);
        external_clock_enable <= ext;
        rc_sysclk <= rc;
        sleep_mode <= m[2:0];
        tick;
        e4 = {asy & ext, asy & ~ext, ~asy & (m == 0 || m == 1 || m == 4),
              asy & (m == 0 || rc & (m == 1 || m == 2 || m == 4))};
        cmp({osc_ext_buf_en, osc_xtal_en, io_clock_keep, osc_clock_keep}, e4);
      end
    end
    @(posedge clock);
    vlcd_ready_pin <= 1'h1;
    for (d = 0; d < 4; d++) begin
      pm = $urandom % 16;
      wr(`SLCD_A_CTRLA, 8'h00);
      for (int k = 0; k < 20; k++) begin
        dm[k] = 8'($urandom);
        wr(6'(`SLCD_A_DMEM_LO + k), dm[k]);
      end
      wr(`SLCD_A_CTRLB, {1'h0, 1'($urandom), d[1:0], pm[3:0]});
      wr(`SLCD_A_FRR, 8'h00);
      e4 = 4'($urandom);
      wr(`SLCD_A_CCR, {4'h0, e4});
      wr(`SLCD_A_CTRLA, {1'h1, 1'($urandom), 6'h00});
      repeat (300) @(posedge clock);
      clr <= 1'h1;
      @(posedge clock);
      clr <= 1'h0;
      repeat (300) @(posedge clock);
      tick;
      cmp(lit, exp_lit(d, pm));
      cmp(seg_lcd_mode, (41'h1 << nseg(pm)) - 41'h1);
      cmp(com_lcd_mode, (1 << (d + 1)) - 1);
      cmp(contrast_level, e4);
      rd(6'(`SLCD_A_DMEM_LO + 19), dm[19]);
    end
    wr(`SLCD_A_CTRLA, 8'h90);
    wait_flag;
    wr(`SLCD_A_CTRLA, 8'h90);
    rd(`SLCD_A_CTRLA, 8'h80);
    wait_flag;
    @(posedge clock);
    flag_vector_ack <= 1'h1;
    @(posedge clock);
    flag_vector_ack <= 1'h0;
    tick;
    cmp(frame_start_flag, 1'h0);
    wr(`SLCD_A_CTRLA, 8'h81);
    repeat (300) @(posedge clock);
    tick;
    cmp({com_level, seg_level}, 88'h0);
    rd(`SLCD_A_DMEM_LO, dm[0]);
    wr(`SLCD_A_CTRLA, 8'h00);
    tick;
    tick;
    cmp({com_lcd_mode, seg_lcd_mode}, 44'h0);
    wr(`SLCD_A_CTRLB, 8'h30);
    // Every prescale code, then every divide factor; the sixteenth pass runs async
    for (int i = 0; i < 16; i++) begin
      ps = i < 8 ? i : 0;
      cd = i < 8 || i == 15 ? 0 : i - 7;
      if (i == 15) wr(`SLCD_A_CTRLB, 8'hB0);
      wr(`SLCD_A_CTRLA, 8'h00);
      wr(`SLCD_A_FRR, {1'h0, ps[2:0], 1'h0, cd[2:0]});
      wr(`SLCD_A_CTRLA, 8'h80);
      tick;
      repeat (3) meas(n);
      cmp(n, (ps == 0 ? 16 : 32 << ps) * (cd + 1) * (i == 15 ? 10 : 1));
    end
    give_verdict;
  end
endmodule // tb_top
